/* File: verilog/msr_pkg.sv */
// Constants and types of the memory scrubber register bank
//==============================================================
// Operation
// R1 - Software reaches every register with full 32-bit transfers only.
// R2 - Bus status shows global correctable and uncorrectable error counts.
// R3 - Bus status bit 13 mirrors the scrubber run-completed flag.
// R4 - Run or block count over threshold sets its flag with new-error.
// R5 - Correctable flag tells correctable indication from bus error reply.
// R6 - New-error flag clears at reset, sets on error, write zero clears.
// R7 - Logged transfer keeps write flag, master number and transfer size.
// R8 - Failing address holds the full address of the logged transfer.
// R9 - Error config holds global thresholds and their two enable bits.
// R10 - Scrub status shows run and block correctable counts, read-only.
// R11 - Run-completed flag set by hardware, software clears with zero.
// R12 - Burst length field gives log2 of bus cycles, eight cycles here.
// R13 - Active bit reads one while a run is in progress, else zero.
// R14 - Configured delay cycles pass between successive blocks.
// R15 - Finish interrupt raised when its config bit is set; the code raises none while the run-completed flag still stands.
// R16 - Second range is also processed when its enable bit is set.
// R17 - Loop bit restarts the scrubber whenever a run finishes.
// R18 - Mode field selects scrub, regenerate or initialize; the code only stores it in config bits 3:2.
// R19 - Config bit 1 allows external start, bit 0 enables scrubber.
// R20 - Range low bits below alignment read zero, high bits read one.
// R21 - Position shows current address while active, else zero.
// R22 - Scrub threshold register holds run and block thresholds, enables.
// R23 - Count over threshold freezes log, sets new-error, interrupts.
// R24 - External start input sets scrubber enable when allowed.
package msr_pkg;

  //==============================================================
  // Register offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_BUS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_FAIL_ADDR    = 8'h04;
  localparam logic [7:0] OFS_ERR_CFG      = 8'h08;
  localparam logic [7:0] OFS_SCRUB_STATUS = 8'h10;
  localparam logic [7:0] OFS_SCRUB_CFG    = 8'h14;
  localparam logic [7:0] OFS_RANGE_LOW    = 8'h18;
  localparam logic [7:0] OFS_RANGE_HIGH   = 8'h1C;
  localparam logic [7:0] OFS_POSITION     = 8'h20;
  localparam logic [7:0] OFS_SCRUB_THR    = 8'h24;
  localparam logic [7:0] OFS_INIT_DATA    = 8'h28;
  localparam logic [7:0] OFS_RANGE2_START = 8'h2C;
  localparam logic [7:0] OFS_RANGE2_END   = 8'h30;

  //==============================================================
  // Field positions
  localparam int CNT_HI = 31;
  localparam int CNT_LO = 22;
  localparam int BLK_HI = 21;
  localparam int BLK_LO = 14;
  localparam int DONE_BIT = 13;
  localparam int NE_BIT = 8;
  localparam int DLY_HI = 15;
  localparam int DLY_LO = 8;
  localparam int IRQ_ON_FINISH_BIT = 7;
  localparam int SECOND_RANGE_EN_BIT = 5;
  localparam int LOOP_BIT = 4;
  localparam int ES_BIT = 1;
  localparam int SCRUBBER_ENABLE_BIT = 0;
  localparam int EN_HI_BIT = 1;
  localparam int EN_LO_BIT = 0;
  localparam int ALIGN = 5;

  //==============================================================
  // Masks, reset values and fixed figures
  localparam logic [31:0] THR_MASK = 32'hFFFF_C003;
  localparam logic [31:0] CFG_MASK = 32'h0000_FFBF;
  localparam logic [31:0] LOW_MASK = 32'h0000_001F;
  localparam logic [31:0] ERR_CFG_RESET = 32'h0000_0003;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] BLOCK_BYTES = 32'h0000_0020;
  localparam logic [3:0] BURST_LOG = 4'h3;
  localparam logic [2:0] BURST_LAST = 3'h7;
  localparam logic [7:0] ONE_DLY = 8'h01;

  //==============================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BURST = 2'b01,
    ST_NEXT  = 2'b11,
    ST_GAP   = 2'b10
  } msr_state_type;

  // Register access request on the AHB slave side
  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic        hready;
  } msr_ahb_req_type;

  // Observed memory bus transfer and error indications
  typedef struct packed {
    logic [31:0] haddr;
    logic        hwrite;
    logic [3:0]  hmaster;
    logic [2:0]  hsize;
    logic        err;
    logic        ce;
  } msr_mon_type;

endpackage

/* File: verilog/msr_status_regs.sv */
// Memory scrubber and bus error status register bank
`timescale 1ns/100ps
`default_nettype none
module msr_status_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // AHB register slave
  input  wire msr_pkg::msr_ahb_req_type ahbReq,
  input  wire logic [31:0]              hwdata,
  output logic [31:0]                   hrdata,
  output logic                          hreadyOut,
  output logic [1:0]                    hresp,
  // Monitored memory bus
  input  wire msr_pkg::msr_mon_type     mon,
  input  wire logic                     startIn,
  // Block outputs
  output logic                          irq,
  output logic                          scrubActive,
  output logic [31:0]                   scrubAddr
);
  import msr_pkg::*;

  logic [31:0] hrdata_r, failAddr_r, errCfg_r, scrCfg_r, scrThr_r;
  logic [31:0] rangeLow_r, rangeHigh_r, range2Lo_r, range2Hi_r, pos_r;
  logic [9:0] corrCnt_r, runCnt_r;
  logic [7:0] uncCnt_r, blkCnt_r, dlyCnt_r;
  logic [3:0] logMst_r;
  logic [2:0] logSz_r, burstCnt_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic wrPend_r, hreadyOut_r, irq_r, active_r, second_r;
  logic ne_r, ce_r, sec_r, sbc_r, done_r, logWr_r;
  msr_state_type st_r;
  logic acc, live, neClr, doneClr, wrCfg, logEvt, gExc, rExc, bExc;
  logic rangeEnd, finish, neSet, doneSet;
  logic [9:0] corrNxt, runNxt;
  logic [7:0] uncNxt, blkNxt;
  logic [31:0] curHigh;

  //==============================================================
  // Register read multiplexer
  function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_BUS_STATUS: readMux = {corrCnt_r, uncCnt_r, done_r, 1'b0, // R2 R3
        sec_r, sbc_r, ce_r, ne_r, logWr_r, logMst_r, logSz_r};
      OFS_FAIL_ADDR:    readMux = failAddr_r; // R8
      OFS_ERR_CFG:      readMux = errCfg_r; // R9
      OFS_SCRUB_STATUS: readMux = {runCnt_r, blkCnt_r, done_r, // R10
        8'h00, BURST_LOG, active_r}; // R12 R13
      OFS_SCRUB_CFG:    readMux = scrCfg_r;
      OFS_RANGE_LOW:    readMux = rangeLow_r & ~LOW_MASK; // R20
      OFS_RANGE_HIGH:   readMux = rangeHigh_r | LOW_MASK; // R20
      OFS_POSITION:     readMux = active_r ? pos_r : ZERO_WORD; // R21
      OFS_SCRUB_THR:    readMux = scrThr_r; // R22
      OFS_RANGE2_START: readMux = range2Lo_r & ~LOW_MASK;
      OFS_RANGE2_END:   readMux = range2Hi_r | LOW_MASK;
      default:          readMux = ZERO_WORD;
    endcase
  endfunction

  //==============================================================
  // Bus slave: address phase capture, zero wait state, always OKAY
  // Whole words are assumed; byte lanes are not decoded
  assign acc = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready; // R1
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      hrdata_r <= ZERO_WORD;
      hreadyOut_r <= 1'b0;
    end else begin
      wrPend_r <= acc & ahbReq.hwrite;
      wrAddr_r <= ahbReq.haddr[ADDR_W-1:0];
      hrdata_r <= (acc & ~ahbReq.hwrite) ?
        readMux(ahbReq.haddr[ADDR_W-1:0]) : ZERO_WORD;
      hreadyOut_r <= 1'b1;
    end
  end

  // Data phase write strobes
  assign neClr = wrPend_r & (wrAddr_r == OFS_BUS_STATUS) & ~hwdata[NE_BIT];
  assign doneClr = wrPend_r & (wrAddr_r == OFS_SCRUB_STATUS)
    & ~hwdata[DONE_BIT];
  assign wrCfg = wrPend_r & (wrAddr_r == OFS_SCRUB_CFG);

  //==============================================================
  // Plain configuration registers; init data is accepted and dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      errCfg_r <= ERR_CFG_RESET;
      scrThr_r <= ZERO_WORD;
      rangeLow_r <= ZERO_WORD;
      rangeHigh_r <= ZERO_WORD;
      range2Lo_r <= ZERO_WORD;
      range2Hi_r <= ZERO_WORD;
    end else if (wrPend_r) begin
      case (wrAddr_r)
        OFS_ERR_CFG:      errCfg_r <= hwdata & THR_MASK; // R9
        OFS_SCRUB_THR:    scrThr_r <= hwdata & THR_MASK; // R22
        OFS_RANGE_LOW:    rangeLow_r <= hwdata;
        OFS_RANGE_HIGH:   rangeHigh_r <= hwdata;
        OFS_RANGE2_START: range2Lo_r <= hwdata;
        OFS_RANGE2_END:   range2Hi_r <= hwdata;
        default: ;
      endcase
    end
  end

  //==============================================================
  // Global error counting and threshold compare
  // Monitoring stays live in the cycle software clears the flag
  assign live = ~ne_r | neClr;
  assign logEvt = live & (mon.err | mon.ce);
  always_comb begin
    corrNxt = neClr ? 10'h000 : corrCnt_r;
    uncNxt = neClr ? 8'h00 : uncCnt_r;
    if (live & mon.ce & ~mon.err & ~&corrNxt) corrNxt = corrNxt + 10'h001;
    if (live & mon.err & ~&uncNxt) uncNxt = uncNxt + 8'h01;
  end
  assign gExc = live & ((mon.ce & ~mon.err & errCfg_r[EN_HI_BIT]
      & (corrNxt > errCfg_r[CNT_HI:CNT_LO]))
    | (mon.err & errCfg_r[EN_LO_BIT]
      & (uncNxt > errCfg_r[BLK_HI:BLK_LO]))); // R23

  //==============================================================
  // Scrub run and block counters; count only during a run
  always_comb begin
    runNxt = runCnt_r;
    blkNxt = blkCnt_r;
    if (active_r & mon.ce & ~&runNxt) runNxt = runNxt + 10'h001;
    if (active_r & mon.ce & ~&blkNxt) blkNxt = blkNxt + 8'h01;
  end
  assign rExc = live & active_r & mon.ce & scrThr_r[EN_HI_BIT]
    & (runNxt > scrThr_r[CNT_HI:CNT_LO]);
  assign bExc = live & active_r & mon.ce & scrThr_r[EN_LO_BIT]
    & (blkNxt > scrThr_r[BLK_HI:BLK_LO]);
  assign neSet = gExc | rExc | bExc;

  //==============================================================
  // Error log; frozen while the new-error flag stands
  always_ff @(posedge clk) begin
    if (reset) begin
      ne_r <= 1'b0;
      ce_r <= 1'b0;
      sec_r <= 1'b0;
      sbc_r <= 1'b0;
      corrCnt_r <= 10'h000;
      uncCnt_r <= 8'h00;
      failAddr_r <= ZERO_WORD;
      logWr_r <= 1'b0;
      logMst_r <= 4'h0;
      logSz_r <= 3'h0;
    end else begin
      corrCnt_r <= corrNxt; // R2
      uncCnt_r <= uncNxt;
      if (logEvt) begin
        failAddr_r <= mon.haddr; // R8
        logWr_r <= mon.hwrite; // R7
        logMst_r <= mon.hmaster;
        logSz_r <= mon.hsize;
        ce_r <= ~mon.err; // R5
      end
      // Set wins over the software clear
      if (neSet) ne_r <= 1'b1; // R6
      else if (neClr) ne_r <= 1'b0;
      if (rExc) sec_r <= 1'b1; // R4
      else if (neClr) sec_r <= 1'b0;
      if (bExc) sbc_r <= 1'b1; // R4
      else if (neClr) sbc_r <= 1'b0;
    end
  end

  //==============================================================
  // Scrub sequencing over one or two ranges
  assign curHigh = second_r ? range2Hi_r : rangeHigh_r;
  assign rangeEnd = pos_r[31:ALIGN] >= curHigh[31:ALIGN];
  assign finish = (st_r == ST_NEXT) & rangeEnd
    & ~(~second_r & scrCfg_r[SECOND_RANGE_EN_BIT]);
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= ST_IDLE;
      pos_r <= ZERO_WORD;
      second_r <= 1'b0;
      burstCnt_r <= 3'h0;
      dlyCnt_r <= 8'h00;
      runCnt_r <= 10'h000;
      blkCnt_r <= 8'h00;
    end else begin
      runCnt_r <= runNxt; // R10
      blkCnt_r <= blkNxt;
      case (st_r)
        ST_IDLE: begin
          if (scrCfg_r[SCRUBBER_ENABLE_BIT]) begin // R19
            st_r <= ST_BURST;
            pos_r <= rangeLow_r & ~LOW_MASK;
            second_r <= 1'b0;
            burstCnt_r <= 3'h0;
            runCnt_r <= 10'h000;
            blkCnt_r <= 8'h00;
          end
        end
        ST_BURST: begin
          burstCnt_r <= burstCnt_r + 3'h1;
          if (burstCnt_r == BURST_LAST) st_r <= ST_NEXT;
        end
        ST_NEXT: begin
          dlyCnt_r <= ONE_DLY;
          st_r <= ST_GAP;
          if (!scrCfg_r[SCRUBBER_ENABLE_BIT]) begin
            st_r <= ST_IDLE;
          end else if (!rangeEnd) begin
            pos_r <= pos_r + BLOCK_BYTES;
          end else if (!finish) begin
            pos_r <= range2Lo_r & ~LOW_MASK; // R16
            second_r <= 1'b1;
          end else if (scrCfg_r[LOOP_BIT]) begin // R17
            pos_r <= rangeLow_r & ~LOW_MASK;
            second_r <= 1'b0;
            runCnt_r <= 10'h000;
          end else begin
            st_r <= ST_IDLE;
          end
        end
        ST_GAP: begin
          dlyCnt_r <= dlyCnt_r + 8'h01;
          if (dlyCnt_r >= scrCfg_r[DLY_HI:DLY_LO]) begin // R14
            st_r <= ST_BURST;
            burstCnt_r <= 3'h0;
            blkCnt_r <= 8'h00;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  //==============================================================
  // Scrub configuration; mode is held and only read back by software
  always_ff @(posedge clk) begin
    if (reset) begin
      scrCfg_r <= ZERO_WORD;
    end else begin
      if (wrCfg) scrCfg_r <= hwdata & CFG_MASK; // R18
      else if (finish & ~scrCfg_r[LOOP_BIT]) scrCfg_r[SCRUBBER_ENABLE_BIT] <= 1'b0;
      if (startIn & scrCfg_r[ES_BIT]) scrCfg_r[SCRUBBER_ENABLE_BIT] <= 1'b1; // R24
    end
  end

  //==============================================================
  // Run-completed flag, activity and interrupt pulse
  assign doneSet = finish & scrCfg_r[SCRUBBER_ENABLE_BIT];
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
      active_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      if (doneSet) done_r <= 1'b1; // R11
      else if (doneClr) done_r <= 1'b0;
      active_r <= (st_r != ST_IDLE) | scrCfg_r[SCRUBBER_ENABLE_BIT]; // R13
      // A standing flag blocks a second finish interrupt
      irq_r <= neSet | (doneSet & ~done_r & scrCfg_r[IRQ_ON_FINISH_BIT]); // R15 R23
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyOut = hreadyOut_r;
  assign hresp = 2'h0;
  assign irq = irq_r;
  assign scrubActive = active_r;
  assign scrubAddr = pos_r;

  //==============================================================
  // Checks
  property p_neIrq;
    @(posedge clk) disable iff (reset) $rose(ne_r) |-> irq_r;
  endproperty
  a_neIrq: assert property (p_neIrq) else $error("new error without irq"); // R23

  property p_neHold;
    @(posedge clk) disable iff (reset) ne_r && !neClr |=> ne_r;
  endproperty
  a_neHold: assert property (p_neHold) else $error("flag lost"); // R6

  property p_freeze;
    @(posedge clk) disable iff (reset)
      ne_r && !neClr |=> $stable(failAddr_r) && $stable(logMst_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("log not frozen"); // R8

  property p_doneMirror;
    @(posedge clk) disable iff (reset)
      acc && !ahbReq.hwrite && ahbReq.haddr[7:0] == OFS_BUS_STATUS
      |=> hrdata_r[DONE_BIT] == $past(done_r);
  endproperty
  a_doneMirror: assert property (p_doneMirror) else $error("mirror"); // R3

  property p_burstLog;
    @(posedge clk) disable iff (reset)
      acc && !ahbReq.hwrite && ahbReq.haddr[7:0] == OFS_SCRUB_STATUS
      |=> hrdata_r[4:1] == 4'h3 && hrdata_r[0] == $past(active_r);
  endproperty
  a_burstLog: assert property (p_burstLog) else $error("scrub stat"); // R12

  property p_highOnes;
    @(posedge clk) disable iff (reset)
      acc && !ahbReq.hwrite && ahbReq.haddr[7:0] == OFS_RANGE_HIGH
      |=> hrdata_r[4:0] == 5'h1F;
  endproperty
  a_highOnes: assert property (p_highOnes) else $error("high bits"); // R20

  property p_posZero;
    @(posedge clk) disable iff (reset)
      acc && !ahbReq.hwrite && ahbReq.haddr[7:0] == OFS_POSITION
      && !active_r |=> hrdata_r == 32'h0000_0000;
  endproperty
  a_posZero: assert property (p_posZero) else $error("position"); // R21

  property p_extStart;
    @(posedge clk) disable iff (reset)
      startIn && scrCfg_r[ES_BIT] |=> scrCfg_r[SCRUBBER_ENABLE_BIT] ##1 active_r;
  endproperty
  a_extStart: assert property (p_extStart) else $error("no start"); // R24

  property p_gap;
    @(posedge clk) disable iff (reset)
      st_r == ST_GAP && dlyCnt_r < scrCfg_r[DLY_HI:DLY_LO]
      && !wrCfg |=> st_r == ST_GAP;
  endproperty
  a_gap: assert property (p_gap) else $error("delay cut short"); // R14

  property p_secNe;
    @(posedge clk) disable iff (reset) $rose(sec_r) |-> ne_r;
  endproperty
  a_secNe: assert property (p_secNe) else $error("run flag alone"); // R4

endmodule
`default_nettype wire

/* File: verif/msr_mem_bus_model.sv */
// Memory bus partner: error replies, correctable flags and start ticks
`timescale 1ns/100ps
`default_nettype none
module msr_mem_bus_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Commands from the bench
  input  wire logic                 fire,
  input  wire logic                 isCe,
  input  wire logic [39:0]          info,
  input  wire logic                 tick,
  // Memory bus side
  output var  msr_pkg::msr_mon_type mon,
  output logic                      startIn
);
  import msr_pkg::*;

  logic [39:0] noise_r;

  //==============================================================
  // Idle transfer info
  // Transfer info is not held between errors, so it churns each cycle
  always_ff @(posedge clk) begin
    if (reset)
      noise_r <= 40'h0;
    else
      noise_r <= noise_r + 40'h13_579B_DF13;
  end

  // One-cycle indication; a correctable one never raises the error reply
  assign mon = fire ? {info, !isCe, isCe} : {noise_r, 2'b00};
  // Timer tick lasts one cycle
  assign startIn = tick;
endmodule
`default_nettype wire

/* File: verif/msr_status_regs_test.sv */
// Self-checking bench of the scrubber status register bank
`timescale 1ns/100ps
`default_nettype none
module msr_status_regs_test;
  import msr_pkg::*;

  localparam int WDOG = 20000;
  localparam logic [7:0] RO[14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
    8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34};
  localparam logic [31:0] RV[14] = '{32'h0, 32'h0, 32'h3, 32'h0, 32'h6,
    32'h0, 32'h0, 32'h1F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1F, 32'h0};
  localparam logic [7:0] WO[10] = '{8'h08, 8'h24, 8'h18, 8'h1C, 8'h2C,
    8'h30, 8'h20, 8'h04, 8'h28, 8'h0C};
  localparam logic [31:0] WA[10] = '{32'hFFFF_C003, 32'hFFFF_C003,
    32'hFFFF_FFE0, 32'hFFFF_FFFF, 32'hFFFF_FFE0, 32'hFFFF_FFFF,
    32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] WB[10] = '{32'h0, 32'h0, 32'h0, 32'h1F,
    32'h0, 32'h1F, 32'h0, 32'h0, 32'h0, 32'h0};

  logic            clk;
  logic            reset;
  msr_ahb_req_type ahbReq;
  logic [31:0]     hwdata;
  logic [31:0]     hrdata;
  logic            hreadyOut;
  logic [1:0]      hresp;
  msr_mon_type     mon;
  logic            startIn;
  logic            irq;
  logic            scrubActive;
  logic [31:0]     scrubAddr;
  logic            fire;
  logic            isCe;
  logic [39:0]     inf;
  logic            tick;
  logic [31:0]     d;
  logic [31:0]     fa;
  logic [31:0]     la;
  logic [31:0]     expV;
  logic [31:0]     mskV;
  logic [31:0]     expQ[$];
  logic [31:0]     mskQ[$];
  int              errors;
  int              nTests;
  int              irqCount;
  int              seed;
  int              i;
  int              c;
  int              cA;
  int              cB;

  //==============================================================
  // Design and partner
  msr_status_regs uut (.clk(clk), .reset(reset), .ahbReq(ahbReq),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyOut(hreadyOut),
    .hresp(hresp), .mon(mon), .startIn(startIn), .irq(irq),
    .scrubActive(scrubActive), .scrubAddr(scrubAddr));
  msr_mem_bus_model bus (.clk(clk), .reset(reset), .fire(fire),
    .isCe(isCe), .info(inf), .tick(tick), .mon(mon), .startIn(startIn));

  // Free-running clock
  always #5 clk = ~clk;

  //==============================================================
  // Checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("Checks %0d, mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read data lives one cycle only, so it is taken mid-cycle
  always @(posedge clk) begin
    if (!reset && ahbReq.hsel && ahbReq.htrans[1] && !ahbReq.hwrite) begin
      @(negedge clk);
      // Notes are taken off first so the mask pairs with its own read
      expV = expQ.pop_front();
      mskV = mskQ.pop_front();
      check(hrdata & mskV, expV & mskV);
    end
  end

  // Interrupt pulses, counted since runs finish at loose moments
  always @(posedge clk) begin
    if (irq === 1'b1)
      irqCount++;
  end

  // Hang guard
  initial begin
    #(WDOG * 10);
    errors++;
    stop_test;
  end

  //==============================================================
  // Drivers
  task automatic addrPhase(input logic w, input logic [7:0] a);
    ahbReq = '{1'b1, 2'b10, w, 3'h2, {24'h0, a}, 1'b1};
    @(negedge clk);
    ahbReq.hsel = 1'b0;
    ahbReq.htrans = 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addrPhase(1'b1, a);
    hwdata = v;
    @(negedge clk);
    hwdata = $random(seed);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    addrPhase(1'b0, a);
    // Idle cycle keeps select from being dropped and raised in one step
    @(negedge clk);
  endtask

  // One error indication; irq is due in the very next cycle
  task automatic err(input logic ce, input logic ei);
    inf = {$random(seed), 8'($random(seed))};
    fire = 1'b1;
    isCe = ce;
    @(negedge clk);
    fire = 1'b0;
    check({31'h0, irq}, {31'h0, ei});
    @(negedge clk);
  endtask

  // Follows one run: first and last position, cycles spent active
  task automatic scrubRun;
    for (i = 0; i < 20 && scrubActive !== 1'b1; i++)
      @(negedge clk);
    fa = scrubAddr;
    for (c = 0; c < 400 && scrubActive === 1'b1; c++) begin
      la = scrubAddr;
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
  endtask

  //==============================================================
  // Scenarios
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    seed = 15079;
    ahbReq = '{1'b0, 2'b00, 1'b0, 3'h2, 32'h0, 1'b1};
    {hwdata, fire, isCe, inf, tick} = '0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check({hresp, 29'h0, hreadyOut}, 32'h1);
    // Reset contents, fixed bits and unmapped places
    for (int k = 0; k < 14; k++)
      rd(RO[k], RV[k], 32'hFFFF_FFFF);
    // Writable fields, fixed alignment bits, read-only places
    for (int k = 0; k < 10; k++) begin
      d = $random(seed);
      wr(WO[k], d);
      rd(WO[k], (d & WA[k]) | WB[k], 32'hFFFF_FFFF);
    end
    for (int k = 0; k < 3; k++) begin
      d = ($random(seed) & 32'h0000_FFB0) | (k << 2);
      wr(8'h14, d);
      rd(8'h14, d, 32'hFFFF_FFFF);
    end
    wr(8'h14, 32'h0);
    wr(8'h08, 32'h3);
    wr(8'h24, 32'h0);
    // Logged reply, then freeze until the new-error flag is cleared
    err(1'b0, 1'b1);
    d = {24'h0, inf[7:0]};
    fa = inf[39:8];
    rd(8'h00, 32'h0000_4100 | d, 32'hFFFF_FFFF);
    rd(8'h04, fa, 32'hFFFF_FFFF);
    err(1'b1, 1'b0);
    rd(8'h00, 32'h0000_4100 | d, 32'hFFFF_FFFF);
    rd(8'h04, fa, 32'hFFFF_FFFF);
    wr(8'h00, 32'h0);
    rd(8'h00, d, 32'hFFFF_FFFF);
    err(1'b1, 1'b1);
    rd(8'h00, 32'h0040_0300 | inf[7:0], 32'hFFFF_FFFF);
    wr(8'h00, 32'h0);
    // Thresholds of one and two
    wr(8'h08, 32'h0080_4003);
    for (int k = 1; k <= 2; k++)
      err(1'b0, k == 2);
    rd(8'h00, 32'h0000_8100 | inf[7:0], 32'hFFFF_FFFF);
    wr(8'h00, 32'h0);
    for (int k = 1; k <= 3; k++)
      err(1'b1, k == 3);
    rd(8'h00, 32'h00C0_0300 | inf[7:0], 32'hFFFF_FFFF);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    err(1'b0, 1'b0);
    wr(8'h00, 32'h0);
    // Run and block counters over a long range
    wr(8'h18, 32'h0000_1000);
    wr(8'h1C, 32'h0000_1FFF);
    wr(8'h24, 32'h0000_0002);
    wr(8'h14, 32'h0000_0101);
    repeat (3) @(negedge clk);
    err(1'b1, 1'b1);
    rd(8'h00, 32'h0000_0B00 | inf[7:0], 32'h0000_3FFF);
    rd(8'h10, 32'h0040_0007, 32'hFFC0_201F);
    rd(8'h20, 32'h0, 32'h0000_001F);
    check({31'h0, scrubActive}, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h24, 32'h0000_0001);
    err(1'b1, 1'b1);
    rd(8'h00, 32'h0000_0700 | inf[7:0], 32'h0000_3FFF);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0);
    for (i = 0; i < 60 && scrubActive !== 1'b0; i++)
      @(negedge clk);
    rd(8'h20, 32'h0, 32'hFFFF_FFFF);
    wr(8'h10, 32'h0);
    // Two-block runs, delays, second range and finish interrupt
    wr(8'h18, 32'h0000_0100);
    wr(8'h1C, 32'h0000_013F);
    wr(8'h2C, 32'h0000_0400);
    wr(8'h30, 32'h0000_041F);
    cA = irqCount;
    wr(8'h14, 32'h0000_0281);
    scrubRun;
    check(fa, 32'h100);
    check(la, 32'h120);
    check(irqCount - cA, 32'h1);
    rd(8'h10, 32'h0000_2006, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_2000, 32'h0000_2000);
    cB = c;
    wr(8'h14, 32'h0000_0A81);
    scrubRun;
    check(c - cB, 32'h8);
    check(irqCount - cA, 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0000_01A1);
    scrubRun;
    check(la, 32'h400);
    check(irqCount - cA, 32'h2);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0000_0101);
    scrubRun;
    check(irqCount - cA, 32'h2);
    wr(8'h10, 32'h0);
    // External start, allowed and not allowed
    wr(8'h14, 32'h0000_0100);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    repeat (5) @(negedge clk);
    check({31'h0, scrubActive}, 32'h0);
    wr(8'h14, 32'h0000_0102);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    scrubRun;
    check(fa, 32'h100);
    wr(8'h10, 32'h0);
    // Loop mode keeps running past a finish
    wr(8'h14, 32'h0000_0111);
    repeat (80) @(negedge clk);
    rd(8'h10, 32'h0000_2001, 32'h0000_2001);
    wr(8'h14, 32'h0);
    for (i = 0; i < 60 && scrubActive !== 1'b0; i++)
      @(negedge clk);
    check({31'h0, scrubActive}, 32'h0);
    repeat (3) @(negedge clk);
    stop_test;
  end
endmodule
`default_nettype wire
